// file: core/pcie_function_power_state_ctrl.sv
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/10ps
// What this block does
// - Only D0u, D0a, D3hot and D3cold exist; D1 and D2 are absent.
// - PME messages go out in every state but D0u and D3cold.
// - Wake pin and beacon work in every state but D0u.
// - PME support and aux current read back follow the aux detect level.
// - Data scale and data select fields always read zero.
// - PME context survives D3cold while aux power is present.
// - Alternate pin use forces the internal aux detect low.
// - Leaving conventional reset puts the function in D0u.
// - A finished function level reset puts the function in D0u.
// - Any space or master enable moves D0u to D0a; D0a then stays.
// - With no soft reset set, D3hot to D0 lands in D0a.
// - Link reaching L2/L3 ready resets the function always.
// - In D3hot only PME requests and completions may be sent.
// - In D3hot only config and message requests are accepted.
// - Unsupported request received in D3hot wakes link and sends error message.
// - Loss of main power gives D3cold; cold reset returns D0u.
// - After link wakes, a PME message names the wake source.
// - ASPM counts link idle in L0 and asks for L0s or L1.
// - Any non-D0 state asks for link L1.
// - D3hot to D0 write with no soft reset clear soft-resets the function.
// - Aux power with PERST asserted gives D3cold; release leaves it.
module pcie_function_power_state_ctrl
  import pm_ctrl_pkg::*;
#(
  parameter int WAKE_W = 4,
  parameter logic [15:0] IDLE_LIMIT_RST = IDLE_RST
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic aux_power_detect_pin,
  input wire logic perst_n,
  input wire logic main_power_good,
  input wire logic link_l2l3_ready,
  input wire logic link_up,
  input wire logic link_idle,
  input wire logic [WAKE_W-1:0] wake_event,
  input wire logic rx_tlp_valid,
  input wire logic [2:0] rx_tlp_kind,
  input wire logic tx_req_is_pme,
  input wire logic tx_req_is_cpl,
  output logic tx_req_allow,
  output logic rx_accept,
  output logic rx_unsupported,
  output logic rx_unexpected_cpl,
  output logic err_msg_req,
  output logic link_l0_req,
  output logic link_l0s_req,
  output logic link_l1_req,
  output logic pme_msg_req,
  output logic [WAKE_W-1:0] pme_msg_src,
  output logic wake_n_o,
  output logic wake_n_oe,
  output logic beacon_req,
  output logic func_reset,
  output logic [1:0] dstate
);

  //////////////////////////////////////////////////////////////////////////////
  // State and register storage
  dstate_type state;
  dstate_type next_state;
  logic io_en, mem_en, bme;
  logic no_soft_reset, pme_en, pme_status, aux_pm_en;
  logic [WAKE_W-1:0] wakeup_source_reg;
  logic err_en, aspm_en, aspm_l1, pin_alt;
  logic [15:0] idle_limit, idle_cnt;
  logic pme_sent, l2l3_q;

  // Write-one-to-clear helper
  function automatic logic w1c(input logic cur, input logic wr, input logic bitv);
    w1c = cur & ~(wr & bitv);
  endfunction : w1c

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire wr_acc = psel & penable & pwrite;
  wire setup = psel & ~penable;
  wire hit_cap = paddr == OFS_PMCAP;
  wire hit_csr = paddr == OFS_PMCSR;
  wire hit_cmd = paddr == OFS_CMD;
  wire hit_dc = paddr == OFS_DEVCTL;
  wire hit_wk = paddr == OFS_WAKESRC;
  wire hit_pc = paddr == OFS_PMCTL;
  wire hit_idl = paddr == OFS_IDLE;
  wire hit_st = paddr == OFS_STATUS;
  wire mapped = hit_cap | hit_csr | hit_cmd | hit_dc | hit_wk | hit_pc | hit_idl | hit_st;
  wire wr_csr = wr_acc & hit_csr;
  wire wr_wk = wr_acc & hit_wk;
  wire [1:0] ps_val = pwdata[1:0];

  //////////////////////////////////////////////////////////////////////////////
  // Power sequencing conditions
  wire aux_det = aux_power_detect_pin & ~pin_alt;
  wire cold_cond = ~main_power_good | (aux_det & ~perst_n);
  wire cold_exit = (state == D3COLD) & ~cold_cond;
  wire l2l3_rise = link_l2l3_ready & ~l2l3_q;
  wire flr_go = wr_acc & hit_dc & pwdata[DC_FLR];
  wire in_d0 = (state == D0U) | (state == D0A);
  wire go_d3 = wr_csr & (ps_val == PS_D3) & in_d0;
  wire go_d0 = wr_csr & (ps_val == PS_D0) & (state == D3HOT);
  wire pm_soft = go_d0 & ~no_soft_reset;
  wire any_en = io_en | mem_en | bme;
  wire func_rst_now = pm_soft | flr_go | l2l3_rise | cold_exit;
  wire ctx_clr = cold_exit & ~aux_det;
  wire pme_pend = pme_status & pme_en;
  wire pme_ok = (state == D0A) | (state == D3HOT);
  wire pme_fire = pme_pend & pme_ok & link_up & ~pme_sent;
  wire aspm_hit = aspm_en & (state == D0A) & link_idle & (idle_cnt == idle_limit);

  // Next function power state; 01b and 10b writes are ignored
  always_comb begin
    next_state = state;
    case (state)
      D0U: begin
        if (go_d3) next_state = D3HOT;
        else if (any_en) next_state = D0A;
      end
      D0A: begin
        if (go_d3) next_state = D3HOT;
      end
      D3HOT: begin
        if (go_d0) next_state = no_soft_reset ? D0A : D0U;
      end
      D3COLD: begin
        next_state = D0U;
      end
      default: next_state = D0U;
    endcase
    if (flr_go || l2l3_rise) next_state = D0U;
    if (cold_cond) next_state = D3COLD;
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) state <= D0U;
    else state <= next_state;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Function context, cleared by any function reset except no_soft_reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_en <= 1'b0;
      mem_en <= 1'b0;
      bme <= 1'b0;
      err_en <= 1'b0;
      no_soft_reset <= 1'b0;
    end else if (func_rst_now) begin
      io_en <= 1'b0;
      mem_en <= 1'b0;
      bme <= 1'b0;
      err_en <= 1'b0;
    end else begin
      if (wr_acc && hit_cmd) begin
        io_en <= pwdata[CMD_IO];
        mem_en <= pwdata[CMD_MEM];
        bme <= pwdata[CMD_BME];
      end
      if (wr_acc && hit_dc) err_en <= pwdata[DC_ERR_EN];
      if (wr_csr) no_soft_reset <= pwdata[CSR_NSR];
    end
  end

  // PME context; survives function resets and D3cold on aux power
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pme_en <= 1'b0;
      aux_pm_en <= 1'b0;
    end else if (ctx_clr) begin
      pme_en <= 1'b0;
      aux_pm_en <= 1'b0;
    end else begin
      if (wr_csr) pme_en <= pwdata[CSR_PME_EN];
      if (wr_acc && hit_dc) aux_pm_en <= pwdata[DC_AUX_PM];
    end
  end

  // Sticky PME status and wake source; a new event beats the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pme_status <= 1'b0;
      wakeup_source_reg <= '0;
    end else if (ctx_clr) begin
      pme_status <= 1'b0;
      wakeup_source_reg <= '0;
    end else begin
      pme_status <= w1c(pme_status, wr_csr, pwdata[CSR_PME_ST]) | (|wake_event);
      wakeup_source_reg <= (wakeup_source_reg & ~({WAKE_W{wr_wk}} & pwdata[WAKE_W-1:0])) | wake_event;
    end
  end

  // Block control and idle limit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aspm_en <= 1'b0;
      aspm_l1 <= 1'b0;
      pin_alt <= 1'b0;
      idle_limit <= IDLE_LIMIT_RST;
    end else begin
      if (wr_acc && hit_pc) begin
        aspm_en <= pwdata[PC_ASPM_EN];
        aspm_l1 <= pwdata[PC_ASPM_L1];
        pin_alt <= pwdata[PC_PIN_ALT];
      end
      if (wr_acc && hit_idl) idle_limit <= pwdata[15:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Link idle counter for ASPM
  always_ff @(posedge clk or posedge rst) begin
    if (rst) idle_cnt <= '0;
    else if (!(link_idle && aspm_en && state == D0A)) idle_cnt <= '0;
    else if (idle_cnt != idle_limit) idle_cnt <= idle_cnt + 16'h0001;
  end

  // Link requests, PME message and reset pulses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      l2l3_q <= 1'b0;
      pme_sent <= 1'b0;
      pme_msg_req <= 1'b0;
      pme_msg_src <= '0;
      err_msg_req <= 1'b0;
      link_l0_req <= 1'b0;
      link_l0s_req <= 1'b0;
      link_l1_req <= 1'b0;
      func_reset <= 1'b0;
    end else begin
      l2l3_q <= link_l2l3_ready;
      pme_sent <= pme_pend & (pme_sent | pme_fire);
      pme_msg_req <= pme_fire;
      if (pme_fire) pme_msg_src <= wakeup_source_reg;
      err_msg_req <= rx_unsupported & err_en;
      link_l0_req <= (rx_unsupported & err_en) | (pme_pend & pme_ok & ~link_up);
      link_l0s_req <= aspm_hit & ~aspm_l1;
      link_l1_req <= ~in_d0 | (aspm_hit & aspm_l1);
      func_reset <= func_rst_now;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // TLP gating
  wire d3h = state == D3HOT;
  wire rx_cfg_msg = (rx_tlp_kind == TLP_CFG) | (rx_tlp_kind == TLP_MSG);
  assign rx_accept = rx_tlp_valid & (~d3h | rx_cfg_msg);
  assign rx_unsupported = rx_tlp_valid & d3h & ~rx_cfg_msg & (rx_tlp_kind != TLP_CPL);
  assign rx_unexpected_cpl = rx_tlp_valid & d3h & (rx_tlp_kind == TLP_CPL);
  assign tx_req_allow = ~d3h | tx_req_is_pme | tx_req_is_cpl;

  // Wake pin is open drain, pulled low while a wake is pending outside D0u
  assign wake_n_o = 1'b0;
  assign wake_n_oe = pme_pend & (state != D0U);
  assign beacon_req = wake_n_oe & ~link_up;
  assign dstate = state;

  //////////////////////////////////////////////////////////////////////////////
  // Read data, captured in the setup phase
  wire [1:0] ps_rd = in_d0 ? PS_D0 : PS_D3;
  wire [31:0] cap_rd = {aux_det ? PME_SUP_AUX : PME_SUP_MAIN, 2'b00,
                        aux_det ? AUX_CUR_ON : AUX_CUR_OFF, 22'h000000};
  wire [31:0] csr_rd = {16'h0000, pme_status, 6'h00, pme_en, 4'h0,
                        no_soft_reset, 1'b0, ps_rd};
  wire [31:0] rd_val =
    hit_cap ? cap_rd :
    hit_csr ? csr_rd :
    hit_cmd ? {29'h0, bme, mem_en, io_en} :
    hit_dc ? {21'h0, aux_pm_en, 9'h0, err_en} :
    hit_wk ? {{(32-WAKE_W){1'b0}}, wakeup_source_reg} :
    hit_pc ? {29'h0, pin_alt, aspm_l1, aspm_en} :
    hit_idl ? {16'h0000, idle_limit} :
    hit_st ? {27'h0, link_l0s_req, link_l1_req, aux_det, state} :
    32'h00000000;

  assign pready = 1'b1;

  // Read data and error flag register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h00000000 : rd_val;
      pslverr <= ~mapped;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence flr_wr;
    flr_go && !cold_cond;
  endsequence

  sequence d0u_enabled;
    state == D0U && any_en && !cold_cond && !go_d3 && !l2l3_rise && !flr_go;
  endsequence

  chk_flr_to_d0u: assert property (flr_wr |=> state == D0U ##0 func_reset)
    else $error("flr did not land in d0u");
  chk_enable_d0a: assert property (d0u_enabled |=> state == D0A)
    else $error("enable did not move to d0a");
  chk_pme_state: assert property (pme_msg_req |-> $past(state) inside {D0A, D3HOT})
    else $error("pme message in wrong state");
  chk_wake_state: assert property (wake_n_oe |-> state != D0U)
    else $error("wake pin driven in d0u");
  chk_alt_low: assert property (pin_alt |-> !aux_det)
    else $error("aux detect not forced low");
  chk_d3_unsup: assert property (rx_tlp_valid && d3h && rx_tlp_kind == TLP_MEM
    |-> rx_unsupported && !rx_accept)
    else $error("mem request accepted in d3hot");
  chk_l1_nond0: assert property (!in_d0 |=> link_l1_req)
    else $error("no l1 request out of d0");
  chk_l2_reset: assert property ($rose(link_l2l3_ready) && !cold_cond |=> func_reset && state == D0U)
    else $error("l2l3 ready did not reset");
  chk_pme_w1c: assert property (wr_csr && pwdata[CSR_PME_ST] && wake_event == '0 && !ctx_clr |=> !pme_status)
    else $error("pme status not cleared");
  chk_nsr_d0a: assert property (go_d0 && no_soft_reset && !cold_cond && !l2l3_rise |=> state == D0A)
    else $error("no soft reset lost context");
  chk_err_msg: assert property (rx_unsupported && err_en |=> err_msg_req && link_l0_req)
    else $error("no error message in d3hot");
  chk_tx_gate: assert property (d3h && !tx_req_is_pme && !tx_req_is_cpl |-> !tx_req_allow)
    else $error("request let out in d3hot");
endmodule : pcie_function_power_state_ctrl

// file: common/pm_ctrl_pkg.sv
package pm_ctrl_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_PMCAP = 8'h00;
  localparam logic [7:0] OFS_PMCSR = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_DEVCTL = 8'h0c;
  localparam logic [7:0] OFS_WAKESRC = 8'h10;
  localparam logic [7:0] OFS_PMCTL = 8'h14;
  localparam logic [7:0] OFS_IDLE = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;

  // Field positions
  localparam int CAP_AUXCUR_LSB = 22;
  localparam int CAP_PMESUP_LSB = 27;
  localparam int CSR_NSR = 3;
  localparam int CSR_PME_EN = 8;
  localparam int CSR_PME_ST = 15;
  localparam int CMD_IO = 0;
  localparam int CMD_MEM = 1;
  localparam int CMD_BME = 2;
  localparam int DC_ERR_EN = 0;
  localparam int DC_AUX_PM = 10;
  localparam int DC_FLR = 15;
  localparam int PC_ASPM_EN = 0;
  localparam int PC_ASPM_L1 = 1;
  localparam int PC_PIN_ALT = 2;

  // Power state field codes
  localparam logic [1:0] PS_D0 = 2'h0;
  localparam logic [1:0] PS_D3 = 2'h3;

  // Capability values
  localparam logic [4:0] PME_SUP_AUX = 5'h19;
  localparam logic [4:0] PME_SUP_MAIN = 5'h09;
  localparam logic [2:0] AUX_CUR_ON = 3'h1;
  localparam logic [2:0] AUX_CUR_OFF = 3'h0;
  localparam logic [15:0] IDLE_RST = 16'h0100;

  // Received TLP kinds
  localparam logic [2:0] TLP_CFG = 3'h0;
  localparam logic [2:0] TLP_MSG = 3'h1;
  localparam logic [2:0] TLP_MEM = 3'h2;
  localparam logic [2:0] TLP_IO = 3'h3;
  localparam logic [2:0] TLP_CPL = 3'h4;

  // Function power states, Gray along D0u-D0a-D3hot-D3cold
  typedef enum logic [1:0] {
    D0U = 2'b00,
    D0A = 2'b01,
    D3HOT = 2'b11,
    D3COLD = 2'b10
  } dstate_type;
endpackage : pm_ctrl_pkg

// file: sim/root_complex_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////
// Host end of the link: drops the link on command and restores
// it when the function asks for L0; counts received messages
module root_complex_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic down,
  input wire logic idle_req,
  input wire logic l23,
  input wire logic link_l0_req,
  input wire logic pme_msg_req,
  input wire logic [3:0] pme_msg_src,
  input wire logic err_msg_req,
  output logic link_up,
  output logic link_idle,
  output logic link_l2l3_ready,
  output logic [7:0] pme_cnt,
  output logic [7:0] err_cnt,
  output logic [3:0] last_src
);
  // Link state and message counters
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link_up <= 1'b1;
      pme_cnt <= 8'h00;
      err_cnt <= 8'h00;
      last_src <= 4'h0;
    end else begin
      if (down) begin
        link_up <= 1'b0;
      end else if (link_l0_req) begin
        link_up <= 1'b1; // Retrain on request
      end
      if (pme_msg_req && link_up) begin
        pme_cnt <= pme_cnt + 8'h01;
        last_src <= pme_msg_src;
      end
      if (err_msg_req) begin
        err_cnt <= err_cnt + 8'h01;
      end
    end
  end

  // Idle is only meaningful while the link is up
  assign link_idle = idle_req && link_up;
  assign link_l2l3_ready = l23;
endmodule : root_complex_model

// file: sim/test_pcie_function_power_state_ctrl.sv
`timescale 1ns/10ps
module test_pcie_function_power_state_ctrl
  import pm_ctrl_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, aux = 1'b1, perst_n = 1'b1;
  logic main_power_good = 1'b1, l23 = 1'b0, down = 1'b0, idl = 1'b0;
  logic rx_tlp_valid = 1'b0, tx_req_is_pme = 1'b0, tx_req_is_cpl = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic [3:0] wake_event = 4'h0, pme_msg_src, src;
  logic [2:0] rx_tlp_kind = 3'h0;
  logic pready, pslverr, tx_req_allow, rx_accept, rx_unsupported, rx_unexpected_cpl;
  logic err_msg_req, link_l0_req, link_l0s_req, link_l1_req, pme_msg_req, wake_n_oe, wake_n_o;
  logic beacon_req, func_reset, link_up, link_idle, link_l2l3_ready;
  logic [1:0] dstate;
  logic [7:0] pc, ec, frc = 8'h00;
  int failures = 0;
  int tests_run = 0;

  always #20 clk = ~clk;

  pcie_function_power_state_ctrl #(.WAKE_W(4), .IDLE_LIMIT_RST(16'h0004)) pcie_function_power_state_ctrl_i (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .aux_power_detect_pin(aux), .perst_n, .main_power_good, .link_l2l3_ready, .link_up,
    .link_idle, .wake_event, .rx_tlp_valid, .rx_tlp_kind, .tx_req_is_pme, .tx_req_is_cpl,
    .tx_req_allow, .rx_accept, .rx_unsupported, .rx_unexpected_cpl, .err_msg_req,
    .link_l0_req, .link_l0s_req, .link_l1_req, .pme_msg_req, .pme_msg_src, .wake_n_o,
    .wake_n_oe, .beacon_req, .func_reset, .dstate);

  root_complex_model root_complex_model_i (
    .clk, .rst, .down, .idle_req(idl), .l23, .link_l0_req, .pme_msg_req, .pme_msg_src,
    .err_msg_req, .link_up, .link_idle, .link_l2l3_ready, .pme_cnt(pc), .err_cnt(ec),
    .last_src(src));

  // Count function reset pulses
  always @(posedge clk) begin
    if (func_reset === 1'b1) frc <= frc + 8'h01;
  end

  ////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // One APB transfer; waits for pready at each access edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Write, then let the state update land
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    cyc(3);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc

  task summarize;
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    cyc(12);
    rst <= 1'b0;
    cyc(1);
    chk(32'(dstate), 32'h0);
    rdc(OFS_PMCAP, 32'hc8400000);
    aux <= 1'b0;
    rdc(OFS_PMCAP, 32'h48000000);
    aux <= 1'b1;
    wr(OFS_PMCTL, 32'h4);
    rdc(OFS_PMCAP, 32'h48000000);
    wr(OFS_PMCTL, 32'h0);
    rdc(8'h20, 32'h0);
    chk(32'(pslverr), 32'h1);
    wr(OFS_PMCSR, 32'h1);
    chk(32'(dstate), 32'h0);
    wr(OFS_CMD, 32'h2);
    chk(32'(dstate), 32'h1);
    wr(OFS_CMD, 32'h0);
    chk(32'(dstate), 32'h1);
    wr(OFS_IDLE, 32'h4);
    wr(OFS_PMCTL, 32'h1);
    idl <= 1'b1;
    cyc(10);
    chk(32'(link_l0s_req), 32'h1);
    wr(OFS_PMCTL, 32'h3);
    chk(32'(link_l1_req), 32'h1);
    chk(32'(link_l0s_req), 32'h0);
    rdc(OFS_STATUS, 32'hd);
    idl <= 1'b0;
    wr(OFS_DEVCTL, 32'h1);
    chk(32'(link_l1_req), 32'h0);
    wr(OFS_PMCSR, 32'h103);
    chk(32'(dstate), 32'h3);
    chk(32'(link_l1_req), 32'h1);
    rdc(OFS_PMCSR, 32'h103);
    // Every received TLP class while in D3hot
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      rx_tlp_valid <= 1'b1;
      rx_tlp_kind <= 3'(k);
      @(negedge clk);
      chk({29'h0, rx_accept, rx_unsupported, rx_unexpected_cpl}, k < 2 ? 32'h4 : (k < 4 ? 32'h2 : 32'h1));
      @(posedge clk);
      rx_tlp_valid <= 1'b0;
    end
    cyc(3);
    chk(32'(ec), 32'h2);
    // Outgoing request kinds: plain request, PME, completion
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      {tx_req_is_cpl, tx_req_is_pme} <= 2'(k);
      @(negedge clk);
      chk(32'(tx_req_allow), 32'(k != 0));
    end
    down <= 1'b1;
    cyc(3);
    down <= 1'b0;
    wake_event <= 4'h2;
    cyc(1);
    wake_event <= 4'h0;
    cyc(20);
    chk(32'(pc), 32'h1);
    chk(32'(src), 32'h2);
    chk(32'({wake_n_oe, wake_n_o}), 32'h2);
    wr(OFS_PMCSR, 32'h8103);
    rdc(OFS_PMCSR, 32'h103);
    wr(OFS_WAKESRC, 32'h2);
    rdc(OFS_WAKESRC, 32'h0);
    wr(OFS_PMCSR, 32'h100);
    chk(32'(dstate), 32'h0);
    chk(32'(frc), 32'h1);
    wr(OFS_CMD, 32'h2);
    wr(OFS_PMCSR, 32'h10b);
    wr(OFS_PMCSR, 32'h108);
    chk(32'(dstate), 32'h1);
    chk(32'(frc), 32'h1);
    wr(OFS_DEVCTL, 32'h8000);
    chk(32'(dstate), 32'h0);
    chk(32'(frc), 32'h2);
    l23 <= 1'b1;
    cyc(3);
    chk(32'(frc), 32'h3);
    l23 <= 1'b0;
    main_power_good <= 1'b0;
    cyc(3);
    chk(32'(dstate), 32'h2);
    main_power_good <= 1'b1;
    cyc(3);
    chk(32'(dstate), 32'h0);
    wr(OFS_CMD, 32'h2);
    wr(OFS_PMCSR, 32'h100);
    perst_n <= 1'b0;
    down <= 1'b1;
    cyc(3);
    chk(32'(dstate), 32'h2);
    wake_event <= 4'h1;
    cyc(1);
    wake_event <= 4'h0;
    cyc(5);
    chk(32'(wake_n_oe), 32'h1);
    chk(32'(beacon_req), 32'h1);
    chk(32'(pc), 32'h1);
    perst_n <= 1'b1;
    cyc(3);
    chk(32'(dstate), 32'h0);
    chk(32'(wake_n_oe), 32'h0);
    chk(32'(beacon_req), 32'h0);
    rdc(OFS_PMCSR, 32'h8100);
    rdc(OFS_WAKESRC, 32'h1);
    summarize();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    summarize();
  end
endmodule : test_pcie_function_power_state_ctrl
